//--- sim/dio_cell_test.sv
// dio_cell_test: self-checking bench for dio_cell with a memory model.
// assumes the assertions inside the design watch the finer timing.
`timescale 1ns/1ps

module dio_cell_test
  import dio_pkg::*;
();
  logic            ref_clk = 1'b0;
  logic            rst_b, gen_clk, cell_ce, cell_lrst, global_tristate;
  logic            tristate_in_pos_phase, tristate_in_neg_phase;
  logic            wr_data_pos, wr_data_neg, dqs_pad, dq_pad, rd_ready;
  logic [1:0]      dll_lag, sel, pol_seen;
  dio_cfg_t        cfg;
  logic            pad_dq_o, cell_tristate_out, pad_oe, sync_pol;
  logic            preamble_seen, rd_valid, rd_overrun, look, go, mem_busy;
  logic            pol_prev, pre_prev, rel;
  logic [7:0]      rd_want;
  logic [1:0]      rd_q[$];
  logic [CAL_W-1:0] dqs_cal;
  dio_pair_t       rd_data;
  logic [7:0]      obs, pattern;
  logic [3:0]      skew;
  logic [31:0]     rnd = 32'h118b;
  logic [7:0]      exp_q[$];
  logic            pre_q[$];
  int              mismatches = 0;
  int              checks_done = 0;
  int              drained = 0;
  // field order: gts cinv rinv ddr lat inv ce lrst pos neg clk expected
  logic [11:0]     rows [31] = '{
    12'h024, 12'h027, 12'h023, 12'h021, 12'h022, 12'h822, 12'h066,
    12'h065, 12'h0a0, 12'h0a5, 12'h0a7, 12'h0a3, 12'h0a0, 12'h129,
    12'h12a, 12'h126, 12'h12d, 12'h12f, 12'h123, 12'h120, 12'h005,
    12'h003, 12'h021, 12'h022, 12'h404, 12'h407, 12'h036, 12'h226,
    12'h234, 12'h237, 12'ha37};

  always #5 ref_clk = ~ref_clk;
  // write data lanes share the tristate lane's structure, so drive both
  assign wr_data_pos = tristate_in_pos_phase;
  assign wr_data_neg = tristate_in_neg_phase;
  assign obs = (sel == 2'h2) ? {7'h00, rd_overrun} :
               (sel == 2'h1) ? {2'h0, dqs_cal} :
               {5'h00, cell_tristate_out, pad_dq_o, pad_oe};

  dio_cell i_dut (.ref_clk, .rst_b, .cfg, .gen_clk, .cell_ce, .cell_lrst,
    .global_tristate, .wr_data_pos, .wr_data_neg, .tristate_in_pos_phase,
    .tristate_in_neg_phase, .dqs_pad, .dq_pad, .dll_lag, .pad_dq_o,
    .cell_tristate_out, .pad_oe, .sync_pol, .preamble_seen, .dqs_cal,
    .rd_valid, .rd_data, .rd_ready, .rd_overrun);

  dio_mem_model i_mem (.go, .pattern, .skew, .dqs_pad, .dq_pad,
    .busy(mem_busy));

  // ******************************
  // helpers
  // ******************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  task automatic cmp(input logic [7:0] got, input logic [7:0] want);
    checks_done++;
    if (got !== want)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, want);
    end
  endtask

  task automatic finish_test();
    if (mismatches == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // expectation is queued, the monitor compares it at the next edge
  task automatic note(input logic [1:0] s, input logic [7:0] v);
    sel = s;
    exp_q.push_back(v);
    look = 1'b1;
    @(negedge ref_clk);
    look = 1'b0;
  endtask

  task automatic lane_step(input logic [11:0] r);
    logic e;
    {global_tristate, cfg.ce_inv, cfg.rst_inv, cfg.ddr_mode, cfg.sdr_latch,
     cfg.clk_inv, cell_ce, cell_lrst, tristate_in_pos_phase,
     tristate_in_neg_phase, gen_clk, e} = r;
    // two synchroniser stages, state, output and enable stages
    repeat (6) @(negedge ref_clk);
    note(2'h0, {5'h00, e, e, ~(r[11] | e)});
  endtask

  task automatic burst(input logic rr);
    rnd = xs(rnd);
    pattern = rnd[7:0];
    skew = rnd[11:8];
    go = 1'b1;
    pre_q.push_back(1'b1);
    // the preamble fall pairs the last release level with itself;
    // without a taker only fifo depth plus the output stage survive
    if (rr || rd_q.size() <= FIFO_DEP)
      rd_q.push_back({rel, rel});
    for (int k = 0; k < 4; k++)
      if (rr || rd_q.size() <= FIFO_DEP)
        rd_q.push_back({pattern[2*k], pattern[2*k+1]});
    rel = ~pattern[7];
    for (int n = 0; n < 300 && (n < 2 || mem_busy); n++)
    begin
      @(negedge ref_clk);
      rnd = xs(rnd);
      rd_ready = rr & rnd[16];
    end
    go = 1'b0;
    // idle gap long enough to re-arm the detector
    repeat (10) @(negedge ref_clk);
  endtask

  // ******************************
  // monitor
  // ******************************
  always @(posedge ref_clk)
  begin
    if (look)
      cmp(obs, exp_q.pop_front());
    if (rst_b && preamble_seen)
    begin
      cmp({7'h00, pre_q.size() != 0}, 8'h01);
      if (pre_q.size() != 0)
        void'(pre_q.pop_front());
      pol_seen[sync_pol] = 1'b1;
    end
    if (rst_b && preamble_seen && pre_prev)
      cmp(8'h01, 8'h00);
    if (rst_b && !preamble_seen && sync_pol !== pol_prev)
      cmp({7'h00, sync_pol}, {7'h00, pol_prev});
    if (rd_valid && rd_ready)
    begin
      drained++;
      rd_want = (rd_q.size() != 0) ? {6'h00, rd_q.pop_front()} : 8'hff;
      cmp({6'h00, rd_data}, rd_want);
    end
    pol_prev = sync_pol;
    pre_prev = preamble_seen;
  end

  initial
  begin
    #100000;
    mismatches++;
    finish_test();
  end

  // ******************************
  // main sequence
  // ******************************
  initial
  begin
    {rst_b, gen_clk, cell_ce, cell_lrst, global_tristate, look, go} = '0;
    {tristate_in_pos_phase, tristate_in_neg_phase, rd_ready} = '0;
    {dll_lag, sel, pol_seen, pattern, skew} = '0;
    {pol_prev, pre_prev, rel} = '0;
    cfg = '0;
    repeat (5) @(negedge ref_clk);
    note(2'h0, 8'h00);
    @(negedge ref_clk);
    note(2'h1, {2'h0, CAL_RST});
    rst_b = 1'b1;
    foreach (rows[i]) lane_step(rows[i]);
    dll_lag = 2'h1;
    repeat (70) @(negedge ref_clk);
    note(2'h1, {2'h0, CAL_MAX});
    cfg.dqs_half = 1'b1;
    repeat (3) @(negedge ref_clk);
    note(2'h1, {2'h0, CAL_MIN});
    dll_lag = 2'h2;
    repeat (70) @(negedge ref_clk);
    note(2'h1, {2'h0, CAL_MAX});
    cfg.dqs_half = 1'b0;
    repeat (3) @(negedge ref_clk);
    note(2'h1, {2'h0, CAL_MIN});
    // right loop down to one tap of delay for the reads
    cfg.dqs_half = 1'b1;
    dll_lag = 2'h0;
    repeat (70) @(negedge ref_clk);
    repeat (3) burst(1'b0);
    note(2'h2, 8'h01);
    drained = 0;
    rd_ready = 1'b1;
    repeat (40) @(negedge ref_clk);
    cmp({7'h00, drained == FIFO_DEP + 1}, 8'h01);
    repeat (12) burst(1'b1);
    cmp({6'h00, pol_seen}, 8'h03);
    {global_tristate, tristate_in_neg_phase, cell_lrst} = '0;
    cfg.rst_inv = 1'b0;
    cfg.clk_sel_dqs = 1'b1;
    burst(1'b1);
    note(2'h0, 8'h01);
    cmp({7'h00, pre_q.size() == 0}, 8'h01);
    finish_test();
  end
endmodule // dio_cell_test

//--- sim/dio_mem_model.sv
// dio_mem_model: behavioural memory side of a read, strobe plus one dq line.
// assumes go is raised by the bench and held until busy has dropped.
`timescale 1ns/1ps

// ******************************
// read burst source
// ******************************
module dio_mem_model
(
  input  wire logic       go,      // start one read burst
  input  wire logic [7:0] pattern, // dq bits, two per strobe period
  input  wire logic [3:0] skew,    // start offset in ns, varies phase
  output logic            dqs_pad, // strobe, idle at termination level
  output logic            dq_pad,  // read data
  output logic            busy     // burst in progress
);
  // termination pulls the undriven strobe high
  initial
  begin
    dqs_pad = 1'b1;
    dq_pad  = 1'b0;
    busy    = 1'b0;
  end

  always @(posedge go)
  begin
    busy = 1'b1;
    #(skew);
    dqs_pad = 1'b0;
    #125;
    for (int i = 0; i < 4; i++)
    begin
      dqs_pad = 1'b1;
      dq_pad  = pattern[2*i];
      #62.5;
      dqs_pad = 1'b0;
      dq_pad  = pattern[2*i+1];
      #62.5;
    end
    #62.5;
    // released lines must not keep showing the last driven value
    dqs_pad = 1'b1;
    dq_pad  = ~dq_pad;
    busy    = 1'b0;
  end
endmodule // dio_mem_model

//--- verilog/dio_cell.sv
// dio_cell: double-rate output/tristate registers, cell control, strobe
// delay with two calibration loops, preamble polarity detection and read
// capture into a small fifo. everything runs on ref_clk; pad pins, the
// strobe and the routing clock are asynchronous and are sampled twice.
//
// Operation
// - double-rate registers exist on read capture and write output paths.
// - tristate path has one single-rate register plus one double-rate latch.
// - single-rate: negative-phase input feeds one element, flip-flop or latch.
// - double-rate: negative phase on rising edge, positive phase latched.
// - double-rate: clock level selects which stored value drives the output.
// - latches pass while their clock is low and hold while it is high.
// - cell clock is routing clock or strobe, optionally inverted.
// - clock enable and local reset come from routing, each optionally inverted.
// - device-wide tristate passes straight through to the output enable.
// - incoming strobe passes a programmable delay before strobe routing.
// - strobe also feeds polarity logic for the synchronising registers.
// - delay setting comes from a six-bit calibration bus of the loops.
// - two loops, each calibrating only the delays in its own half.
// - each loop tracks using the system clock and its own feedback.
// - polarity picks the system clock edge that captures read data.
// - polarity is re-evaluated at the start of every read.
// - a detector senses idle-to-low and sets the synchronising polarity.
`timescale 1ns/1ps

// ******************************
// read fifo
// ******************************
module dio_fifo
  import dio_pkg::*;
#(
  parameter int WIDTH = 2,
  parameter int DEPTH = FIFO_DEP
)(
  input  wire logic             ref_clk,   // system clock
  input  wire logic             rst_b,     // sync reset, active low
  input  wire logic             in_valid,  // push request
  output logic                  in_ready,  // room available
  input  wire logic [WIDTH-1:0] in_data,   // pushed word
  output logic                  out_valid, // word available
  input  wire logic             out_ready, // pop request
  output logic      [WIDTH-1:0] out_data   // head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rp_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge ref_clk)
  begin
    if (push)
      mem_r[wp_r] <= in_data;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
        wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      if (pop)
        rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // dio_fifo

// ******************************
// pad cell top
// ******************************
module dio_cell
  import dio_pkg::*;
(
  input  wire logic      ref_clk,               // system clock, 100 MHz
  input  wire logic      rst_b,                 // sync reset, active low
  input  wire dio_cfg_t  cfg,                   // static cell configuration
  input  wire logic      gen_clk,               // routing clock, async
  input  wire logic      cell_ce,               // clock enable, async
  input  wire logic      cell_lrst,             // local reset, async
  input  wire logic      global_tristate,       // device-wide tristate
  input  wire logic      wr_data_pos,           // write data, positive phase
  input  wire logic      wr_data_neg,           // write data, negative phase
  input  wire logic      tristate_in_pos_phase, // tristate, positive phase
  input  wire logic      tristate_in_neg_phase, // tristate, negative phase
  input  wire logic      dqs_pad,               // strobe from memory, async
  input  wire logic      dq_pad,                // read data pin, async
  input  wire logic [1:0] dll_lag,              // loop feedback, 1 = too short
  output logic           pad_dq_o,              // write data to pad
  output logic           cell_tristate_out,     // registered tristate
  output logic           pad_oe,                // pad driver enable
  output logic           sync_pol,              // synchronising polarity
  output logic           preamble_seen,         // one-cycle detect pulse
  output logic [CAL_W-1:0] dqs_cal,             // calibration in use
  output logic           rd_valid,              // read pair valid
  output dio_pair_t      rd_data,               // read pair
  input  wire logic      rd_ready,              // read pair taken
  output logic           rd_overrun             // sticky: pair dropped
);

  // ******************************
  // input synchronisers
  // ******************************
  localparam int NSYNC = 8;
  logic [NSYNC-1:0] s1_r;
  logic [NSYNC-1:0] s2_r;
  logic gen_clk_s, ce_s, lrst_s, gts_s, dqs_s, dq_s;
  logic [1:0] lag_s;

  always_ff @(posedge ref_clk)
  begin
    s1_r <= {dll_lag, dq_pad, dqs_pad, global_tristate, cell_lrst,
             cell_ce, gen_clk} ;
    s2_r <= s1_r;
  end
  assign {lag_s, dq_s, dqs_s, gts_s, lrst_s, ce_s, gen_clk_s} = s2_r;

  // ******************************
  // calibration loops and strobe delay
  // ******************************
  logic [CAL_W-1:0]    cal_r [2];
  logic [DLY_TAPS-1:0] dly_sr_r;
  logic [CAL_W-1:0]    cal_sel;
  logic                dqs_dly;

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_dll
      // each loop steps one tap per cycle toward its feedback target
      always_ff @(posedge ref_clk)
      begin
        if (!rst_b)
          cal_r[g] <= CAL_RST;
        else if (lag_s[g] && cal_r[g] != CAL_MAX)
          cal_r[g] <= cal_r[g] + 1'b1;
        else if (!lag_s[g] && cal_r[g] != CAL_MIN)
          cal_r[g] <= cal_r[g] - 1'b1;
      end
    end
  endgenerate

  assign cal_sel = cfg.dqs_half ? cal_r[1] : cal_r[0];

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      dly_sr_r <= '0;
    else
      dly_sr_r <= {dly_sr_r[DLY_TAPS-2:0], dqs_s};
  end
  // delay resolution is one system clock per tap
  assign dqs_dly = dly_sr_r[cal_sel];

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      dqs_cal <= CAL_RST;
    else
      dqs_cal <= cal_sel;
  end

  // ******************************
  // cell control
  // ******************************
  logic cclk;
  logic cclk_prev_r;
  logic crise;
  logic ce_eff;
  logic lrst_eff;

  assign cclk     = (cfg.clk_sel_dqs ? dqs_dly : gen_clk_s)
                    ^ cfg.clk_inv;
  assign ce_eff   = ce_s ^ cfg.ce_inv;
  assign lrst_eff = lrst_s ^ cfg.rst_inv;
  assign crise    = cclk & ~cclk_prev_r;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      cclk_prev_r <= 1'b0;
    else
      cclk_prev_r <= cclk;
  end

  // ******************************
  // output and tristate lanes
  // ******************************
  logic ff_r   [LANES];
  logic lat_r  [LANES];
  logic out_r  [LANES];
  logic pos_in [LANES];
  logic neg_in [LANES];

  assign pos_in[LANE_DAT] = wr_data_pos;
  assign neg_in[LANE_DAT] = wr_data_neg;
  assign pos_in[LANE_TRI] = tristate_in_pos_phase;
  assign neg_in[LANE_TRI] = tristate_in_neg_phase;

  generate
    for (g = 0; g < LANES; g++)
    begin : g_lane
      always_ff @(posedge ref_clk)
      begin
        if (!rst_b || lrst_eff)
          ff_r[g] <= 1'b0;
        else if (crise && ce_eff)
          ff_r[g] <= neg_in[g];
      end

      // transparent while the cell clock is low
      always_ff @(posedge ref_clk)
      begin
        if (!rst_b || lrst_eff)
          lat_r[g] <= 1'b0;
        else if (!cclk && ce_eff)
          lat_r[g] <= cfg.ddr_mode ? pos_in[g] : neg_in[g];
      end

      always_ff @(posedge ref_clk)
      begin
        if (!rst_b)
          out_r[g] <= 1'b0;
        else if (cfg.ddr_mode)
          out_r[g] <= cclk ? ff_r[g] : lat_r[g];
        else
          out_r[g] <= cfg.sdr_latch ? lat_r[g] : ff_r[g];
      end
    end
  endgenerate

  assign pad_dq_o          = out_r[LANE_DAT];
  assign cell_tristate_out = out_r[LANE_TRI];

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      pad_oe <= 1'b0;
    else
      pad_oe <= ~(gts_s | out_r[LANE_TRI]);
  end

  // ******************************
  // preamble detector and polarity
  // ******************************
  dio_det_t         det_r;
  logic [CNT_W-1:0] idle_cnt_r;
  logic             phase_r;
  logic             det_hit;

  // phase_r stands for the system clock half in which a word is taken
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      phase_r <= 1'b0;
    else
      phase_r <= ~phase_r;
  end

  assign det_hit = (det_r == DET_ARMED) && !dqs_s;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      det_r      <= DET_WAIT;
      idle_cnt_r <= '0;
    end
    else
    begin
      unique case (det_r)
        DET_WAIT:
        begin
          if (!dqs_s)
            idle_cnt_r <= '0;
          else if (idle_cnt_r == CNT_ARM)
            det_r <= DET_ARMED;
          else
            idle_cnt_r <= idle_cnt_r + 1'b1;
        end
        DET_ARMED:
        begin
          if (!dqs_s)
          begin
            det_r      <= DET_WAIT;
            idle_cnt_r <= '0;
          end
        end
        default:
        begin
          det_r      <= DET_WAIT;
          idle_cnt_r <= '0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      sync_pol      <= 1'b0;
      preamble_seen <= 1'b0;
    end
    else
    begin
      preamble_seen <= det_hit;
      if (det_hit)
        sync_pol <= phase_r;
    end
  end

  // ******************************
  // read capture and synchronising register
  // ******************************
  logic      dly_prev_r;
  logic      cap_pos_r;
  logic      cap_neg_r;
  logic      pair_rdy_r;
  logic      push;
  logic      f_in_ready;
  logic      f_out_valid;
  logic      f_pop;
  dio_pair_t f_out;

  assign push = pair_rdy_r && (phase_r == sync_pol);

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      dly_prev_r <= 1'b0;
      cap_pos_r  <= 1'b0;
      cap_neg_r  <= 1'b0;
      pair_rdy_r <= 1'b0;
    end
    else
    begin
      dly_prev_r <= dqs_dly;
      if (dqs_dly && !dly_prev_r)
        cap_pos_r <= dq_s;
      // a new pair wins over the take of the previous one
      if (!dqs_dly && dly_prev_r)
      begin
        cap_neg_r  <= dq_s;
        pair_rdy_r <= 1'b1;
      end
      else if (push)
        pair_rdy_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      rd_overrun <= 1'b0;
    else if (push && !f_in_ready)
      rd_overrun <= 1'b1;
  end

  dio_fifo #(
    .WIDTH ($bits(dio_pair_t)),
    .DEPTH (FIFO_DEP)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .in_valid  (push),
    .in_ready  (f_in_ready),
    .in_data   ({cap_pos_r, cap_neg_r}),
    .out_valid (f_out_valid),
    .out_ready (f_pop),
    .out_data  (f_out)
  );

  // output stage keeps the read port flop-driven
  assign f_pop = f_out_valid && (!rd_valid || rd_ready);

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      rd_valid <= 1'b0;
      rd_data  <= '0;
    end
    else if (!rd_valid || rd_ready)
    begin
      rd_valid <= f_out_valid;
      if (f_pop)
        rd_data <= f_out;
    end
  end

  // ******************************
  // assertions
  // ******************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence s_quiet;
    dqs_s [*8];
  endsequence

  sequence s_drop;
    (det_r == DET_ARMED) && !dqs_s;
  endsequence

  a_quiet_arms: assert property (s_quiet |=> det_r == DET_ARMED)
    else $error("detector not armed after idle strobe");
  a_drop_fires: assert property (s_drop |=> preamble_seen)
    else $error("preamble not flagged");
  a_pol_value: assert property (s_drop |=> sync_pol == $past(phase_r))
    else $error("polarity not taken from detection phase");
  a_pol_hold: assert property ($changed(sync_pol) |-> preamble_seen)
    else $error("polarity changed without detection");
  a_push_pol: assert property (
      pair_rdy_r && phase_r == sync_pol && f_in_ready
      && !(!dqs_dly && dly_prev_r) |=> !pair_rdy_r ##1 1'b1)
    else $error("pair not taken on selected edge");
  a_oe_gts: assert property (gts_s |=> !pad_oe)
    else $error("output enable active under global tristate");
  a_latch_hold: assert property (
      cclk && !lrst_eff |=> $stable(lat_r[LANE_TRI]))
    else $error("latch moved while clock high");
  a_sdr_ff: assert property (
      !cfg.ddr_mode && crise && ce_eff && !lrst_eff
      |=> ff_r[LANE_TRI] == $past(tristate_in_neg_phase))
    else $error("single-rate capture wrong");
  a_ddr_mux: assert property (
      cfg.ddr_mode && !cclk |=> cell_tristate_out == $past(lat_r[LANE_TRI]))
    else $error("low phase must drive the latched value");
  a_cal_step: assert property (
      lag_s[0] && cal_r[0] != CAL_MAX |=> cal_r[0] == $past(cal_r[0]) + 1'b1)
    else $error("loop did not step up");

endmodule // dio_cell

//--- verilog/dio_pkg.sv
// dio_pkg: shared constants and types for the double-rate pad cell logic.
// assumes a single system clock; all widths below are the defaults.
package dio_pkg;

  // ******************************
  // sizes and timing
  // ******************************
  localparam int CAL_W     = 6;           // calibration bus width
  localparam int DLY_TAPS  = 1 << CAL_W;  // taps of the strobe delay line
  // must outlast a strobe high phase, or burst falls pass for preambles
  localparam int IDLE_MIN  = 8;           // idle-high cycles to arm detector
  localparam int CNT_W     = 3;
  localparam int FIFO_DEP  = 8;
  localparam int LANES     = 2;           // lane 0 write data, lane 1 tristate
  localparam int LANE_DAT  = 0;
  localparam int LANE_TRI  = 1;
  localparam logic [CAL_W-1:0] CAL_RST = 6'h20;  // mid-scale start point
  localparam logic [CAL_W-1:0] CAL_MAX = 6'h3f;
  localparam logic [CAL_W-1:0] CAL_MIN = 6'h00;
  localparam logic [CNT_W-1:0] CNT_ARM = 3'h7;   // IDLE_MIN - 1

  // ******************************
  // types
  // ******************************
  typedef struct packed {
    logic ddr_mode;    // double-rate lanes
    logic sdr_latch;   // single-rate element acts as a latch
    logic clk_sel_dqs; // cell clock from delayed strobe
    logic clk_inv;
    logic ce_inv;
    logic rst_inv;
    logic dqs_half;    // 1: served by the right-side loop
  } dio_cfg_t;

  typedef struct packed {
    logic pos;
    logic neg;
  } dio_pair_t;

  typedef enum logic [1:0] {
    DET_WAIT  = 2'b01,
    DET_ARMED = 2'b10
  } dio_det_t;

endpackage
